// ===== hw/beam_eval.sv
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module beam_eval (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // beam scan
  input  wire logic [15:0]          beam_status,
  input  wire logic                 scan_done,
  // selector switches, two lines each except strobe_in, which has one
  input  wire logic [3:0]           rx_sw_a,
  input  wire logic [3:0]           rx_sw_b,
  input  wire logic                 tx_near_a,
  input  wire logic                 tx_near_b,
  input  wire logic                 strobe_in,
  // outputs
  output logic [13:0]               analog_mv,
  output logic                      wire_sync_sel,
  output logic                      near_sel,
  output logic                      align_mode,
  output logic [15:0]               align_led,
  output logic                      sync_lost
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic        cfg_done;
    logic [3:0]  rx_sw;
    logic        near;
    logic        align;
    logic        mism;
    logic        slost;
    logic        en;
    logic [4:0]  first_blk;
    logic [4:0]  first_opn;
    logic [4:0]  last_blk;
    logic [4:0]  last_opn;
    logic [4:0]  count;
    logic [4:0]  span;
    logic [13:0] mv;
    logic [15:0] led;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // per-beam evaluation
  logic [4:0]  fb;
  logic [4:0]  fo;
  logic [4:0]  lb;
  logic [4:0]  lo;
  logic [4:0]  cnt;
  logic [4:0]  spn;
  logic [4:0]  src_val;
  logic [31:0] prod;
  logic [13:0] mv_lin;
  logic [13:0] mv_out;
  logic        addr_ok;
  logic [7:0]  a_ofs;
  logic [31:0] rd_val;

  // chains run from beam 1 upward, entry g covers beams 1..g
  logic [4:0]  fb_ch  [0:beam_eval_pkg::BEAMS];
  logic [4:0]  fo_ch  [0:beam_eval_pkg::BEAMS];
  logic [4:0]  lb_ch  [0:beam_eval_pkg::BEAMS];
  logic [4:0]  lo_ch  [0:beam_eval_pkg::BEAMS];
  logic [4:0]  cnt_ch [0:beam_eval_pkg::BEAMS];

  assign fb_ch[0]  = 5'h00;
  assign fo_ch[0]  = 5'h00;
  assign lb_ch[0]  = 5'h00;
  assign lo_ch[0]  = 5'h00;
  assign cnt_ch[0] = 5'h00;

  // beam_status[g] is beam g+1, index 1 farthest from the connector
  for (genvar g = 0; g < beam_eval_pkg::BEAMS; g++) begin : g_beam
    localparam logic [4:0] IDX = 5'(g + 1);
    logic blk;

    assign blk = beam_status[g];

    // lowest index keeps the first hit
    assign fb_ch[g + 1] = (fb_ch[g] != 5'h00) ? fb_ch[g] :
                          (blk ? IDX : 5'h00);
    assign fo_ch[g + 1] = (fo_ch[g] != 5'h00) ? fo_ch[g] :
                          (!blk ? IDX : 5'h00);

    // highest index keeps the last hit
    assign lb_ch[g + 1] = blk ? IDX : lb_ch[g];
    assign lo_ch[g + 1] = blk ? lo_ch[g] : IDX;

    // holes add nothing to the count
    assign cnt_ch[g + 1] = cnt_ch[g] + {4'h0, blk};
  end

  assign fb  = fb_ch[beam_eval_pkg::BEAMS];
  assign fo  = fo_ch[beam_eval_pkg::BEAMS];
  assign lb  = lb_ch[beam_eval_pkg::BEAMS];
  assign lo  = lo_ch[beam_eval_pkg::BEAMS];
  assign cnt = cnt_ch[beam_eval_pkg::BEAMS];

  // span counts beams from first to last blocked, both included
  assign spn = (fb == 5'h00) ? 5'h00 : 5'(lb - fb + 5'h01);

  ////////////////////////////////////////////////////////////////////////////
  // analogue source and scaling
  always_comb begin
    case (beam_eval_pkg::src_sel_t'(st_r.rx_sw[beam_eval_pkg::SW_SEL_HI:
                                              beam_eval_pkg::SW_SEL_LO]))
      beam_eval_pkg::SRC_SPAN:  src_val = spn;
      beam_eval_pkg::SRC_LAST:  src_val = lb;
      beam_eval_pkg::SRC_COUNT: src_val = cnt;
      beam_eval_pkg::SRC_FIRST: src_val = fb;
      default:                  src_val = spn;
    endcase
    prod   = 32'(src_val) * 32'(beam_eval_pkg::FULL_MV) / 32'(beam_eval_pkg::BEAMS_W);
    mv_lin = prod[13:0];
    mv_out = st_r.rx_sw[beam_eval_pkg::SW_POL] ?
             14'(beam_eval_pkg::FULL_MV - mv_lin) : mv_lin;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read mux
  always_comb begin
    a_ofs   = haddr[7:0];
    addr_ok = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0);
    rd_val  = 32'h0000_0000;
    if (addr_ok) begin
      case (a_ofs)
        beam_eval_pkg::CTRL_OFS:   rd_val = {31'h0000_0000, st_r.en};
        beam_eval_pkg::FIRST_OFS:  rd_val = {11'h000, st_r.first_opn, 11'h000, st_r.first_blk};
        beam_eval_pkg::LAST_OFS:   rd_val = {11'h000, st_r.last_opn, 11'h000, st_r.last_blk};
        beam_eval_pkg::COUNT_OFS:  rd_val = {11'h000, st_r.span, 11'h000, st_r.count};
        beam_eval_pkg::ANALOG_OFS: rd_val = {18'h0_0000, st_r.mv};
        beam_eval_pkg::STATUS_OFS: begin
          rd_val[beam_eval_pkg::ST_SYNC]  = st_r.rx_sw[beam_eval_pkg::SW_SYNC];
          rd_val[beam_eval_pkg::ST_POL]   = st_r.rx_sw[beam_eval_pkg::SW_POL];
          rd_val[beam_eval_pkg::ST_SEL+:2] = st_r.rx_sw[beam_eval_pkg::SW_SEL_HI:
                                                       beam_eval_pkg::SW_SEL_LO];
          rd_val[beam_eval_pkg::ST_NEAR]  = st_r.near;
          rd_val[beam_eval_pkg::ST_ALIGN] = st_r.align;
          rd_val[beam_eval_pkg::ST_MISM]  = st_r.mism;
          rd_val[beam_eval_pkg::ST_SLOST] = st_r.slost;
          rd_val[beam_eval_pkg::ST_DONE]  = st_r.cfg_done;
        end
        default:                   rd_val = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // both switch lines must agree bit by bit
  logic [3:0]  sw_diff;

  for (genvar s = 0; s < 4; s++) begin : g_swline
    assign sw_diff[s] = rx_sw_a[s] ^ rx_sw_b[s];
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_nxt = st_r;
    // switches and strobe caught once, first edge after reset release
    if (!st_r.cfg_done) begin
      st_nxt.cfg_done = 1'b1;
      st_nxt.rx_sw    = rx_sw_a;
      st_nxt.near     = tx_near_a;
      st_nxt.align    = strobe_in;
      st_nxt.mism     = (|sw_diff) || (tx_near_a != tx_near_b);
    end
    if (scan_done && st_r.cfg_done && st_r.en) begin
      st_nxt.first_blk = fb;
      st_nxt.first_opn = fo;
      st_nxt.last_blk  = lb;
      st_nxt.last_opn  = lo;
      st_nxt.count     = cnt;
      st_nxt.span      = spn;
      st_nxt.mv        = mv_out;
      // optical sync rides on beam 1
      st_nxt.slost     = !st_r.rx_sw[beam_eval_pkg::SW_SYNC] && beam_status[0];
      st_nxt.led       = st_r.align ? ~beam_status : 16'h0000;
    end
    // ahb data phase write
    st_nxt.wr_pend = 1'b0;
    if (st_r.wr_pend && st_r.wr_addr == beam_eval_pkg::CTRL_OFS) begin
      st_nxt.en = hwdata[beam_eval_pkg::CTRL_EN];
    end
    // ahb address phase
    if (hsel && hready && htrans[1]) begin
      st_nxt.wr_pend = hwrite && addr_ok;
      st_nxt.wr_addr = a_ofs;
      st_nxt.rdata   = hwrite ? 32'h0000_0000 : rd_val;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r    <= '0;
      st_r.en <= beam_eval_pkg::CTRL_RST[0];
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = st_r.rdata;
  assign analog_mv     = st_r.mv;
  assign wire_sync_sel = st_r.rx_sw[beam_eval_pkg::SW_SYNC];
  assign near_sel      = st_r.near;
  assign align_mode    = st_r.align;
  assign align_led     = st_r.led;
  assign sync_lost     = st_r.slost;

endmodule

// ===== common/beam_eval_pkg.sv
package beam_eval_pkg;

  // beam array
  localparam int          BEAMS      = 16;
  localparam int          IDX_W      = 5;
  localparam logic [4:0]  BEAMS_W    = 5'h10;

  // analogue scaling: millivolt code, full scale ten volts
  localparam int          FULL_VOLT  = 10;
  localparam int          MV_PER_V   = 1000;
  localparam int          MV_W       = 14;
  localparam logic [13:0] FULL_MV    = 14'(FULL_VOLT * MV_PER_V);

  // receiver switch line fields
  localparam int          SW_SYNC    = 0;
  localparam int          SW_POL     = 1;
  localparam int          SW_SEL_LO  = 2;
  localparam int          SW_SEL_HI  = 3;

  // analogue source select
  typedef enum logic [1:0] {
    SRC_SPAN  = 2'h0,
    SRC_LAST  = 2'h1,
    SRC_COUNT = 2'h2,
    SRC_FIRST = 2'h3
  } src_sel_t;

  // register byte offsets
  localparam logic [7:0]  CTRL_OFS   = 8'h00;
  localparam logic [7:0]  FIRST_OFS  = 8'h04;
  localparam logic [7:0]  LAST_OFS   = 8'h08;
  localparam logic [7:0]  COUNT_OFS  = 8'h0C;
  localparam logic [7:0]  ANALOG_OFS = 8'h10;
  localparam logic [7:0]  STATUS_OFS = 8'h14;

  // control register
  localparam int          CTRL_EN    = 0;
  localparam logic [0:0]  CTRL_RST   = 1'h1;

  // status register fields
  localparam int          ST_SYNC    = 0;
  localparam int          ST_POL     = 1;
  localparam int          ST_SEL     = 2;
  localparam int          ST_NEAR    = 4;
  localparam int          ST_ALIGN   = 5;
  localparam int          ST_MISM    = 6;
  localparam int          ST_SLOST   = 7;
  localparam int          ST_DONE    = 8;

  // ahb
  localparam logic [1:0]  HTRANS_NSQ = 2'h2;

endpackage

// ===== testbench/beam_eval_props.sv
`timescale 1ns/1ps
module beam_eval_props (
  // clock, reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // watched
  input wire logic [15:0] beam_status,
  input wire logic        scan_done,
  input wire logic [3:0]  rx_sw_a,
  input wire logic        tx_near_a,
  input wire logic        strobe_in,
  input wire logic [13:0] analog_mv,
  input wire logic        wire_sync_sel,
  input wire logic        near_sel,
  input wire logic        align_mode,
  input wire logic [15:0] align_led,
  input wire logic        sync_lost
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_LED: assert property (
    scan_done && $past(hresetn) |=> align_led == (align_mode ? ~$past(beam_status) : 16'h0000)
  ) else $error("align led wrong");
  AST_LED_OFF: assert property (!align_mode |-> align_led == 16'h0000)
    else $error("align led lit");
  AST_SYNC: assert property (
    scan_done && $past(hresetn) |=> sync_lost == (!wire_sync_sel && $past(beam_status[0]))
  ) else $error("sync lost wrong");
  AST_COUNT: assert property (
    scan_done && $past(hresetn) && rx_sw_a[3:1] == 3'b100
    |=> analog_mv == 14'($countones($past(beam_status)) * beam_eval_pkg::FULL_MV / 16)
  ) else $error("count scaling wrong");
  AST_RANGE: assert property (analog_mv <= beam_eval_pkg::FULL_MV)
    else $error("analog over range");
  AST_HOLD: assert property (!scan_done |=> $stable(analog_mv))
    else $error("analog moved");
  AST_CFG: assert property (
    !$past(hresetn) |=> near_sel == $past(tx_near_a) && align_mode == $past(strobe_in)
  ) else $error("config not latched");
  AST_CFG_HOLD: assert property (
    $past(hresetn, 2) && $past(hresetn) |-> $stable(near_sel) && $stable(wire_sync_sel)
  ) else $error("config moved");
endmodule
bind beam_eval beam_eval_props u_props (.hclk, .hresetn, .beam_status, .scan_done, .rx_sw_a,
  .tx_near_a, .strobe_in, .analog_mv, .wire_sync_sel, .near_sel, .align_mode, .align_led,
  .sync_lost);

// ===== testbench/beam_emitter_model.sv
`timescale 1ns/1ps
module beam_emitter_model (
  // request
  input  wire logic        hclk,
  input  wire logic        start,
  input  wire logic [15:0] pattern,
  // receiver view
  output logic [15:0]      beam_status = 16'h0000,
  output logic             scan_done = 1'b0
);
  always @(posedge hclk) begin
    scan_done   <= start;
    beam_status <= start ? pattern : ~beam_status;
  end
endmodule

// ===== testbench/beam_eval_test.sv
`timescale 1ns/1ps
module beam_eval_test;
  localparam int FS = beam_eval_pkg::FULL_VOLT * beam_eval_pkg::MV_PER_V;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, start = 1'b0;
  logic strobe_in = 1'b0, tx_near = 1'b0, mis = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [3:0]  rx_sw = 4'h0;
  logic [15:0] pattern = 16'h0000;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
  wire logic hready, hreadyout, hresp, scan_done, wire_sync_sel, near_sel, align_mode, sync_lost;
  wire logic [31:0] hrdata;
  wire logic [15:0] beam_status, align_led;
  wire logic [13:0] analog_mv;
  int n_mismatch = 0;
  int checks = 0;
  int v1 [4] = '{7, 8, 3, 2};
  int v2 [4] = '{16, 16, 16, 1};
  assign hready = hreadyout;
  always #2.5 hclk = ~hclk;
  beam_emitter_model emitter (.hclk, .start, .pattern, .beam_status, .scan_done);
  beam_eval DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .beam_status, .scan_done, .rx_sw_a(rx_sw),
    .rx_sw_b(rx_sw ^ {3'h0, mis}), .tx_near_a(tx_near), .tx_near_b(tx_near),
    .strobe_in, .analog_mv,
    .wire_sync_sel, .near_sel, .align_mode, .align_led, .sync_lost);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] exp_mv(input int v, input int inv);
    int m = v * FS / beam_eval_pkg::BEAMS;
    return 32'(inv ? FS - m : m);
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
      n_mismatch++;
    end
  endtask
  task automatic wt;
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      n_mismatch++;
      final_report();
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input string nm);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= beam_eval_pkg::HTRANS_NSQ;
    haddr  <= a;
    hwrite <= w;
    wt();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    if (!w) chk(nm, d, hrdata);
  endtask
  task automatic scan(input logic [15:0] p);
    @(posedge hclk);
    start   <= 1'b1;
    pattern <= p;
    @(posedge hclk);
    start   <= 1'b0;
    @(posedge hclk);
    @(negedge hclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 4; i++) begin
      @(posedge hclk);
      hresetn   <= 1'b0;
      rx_sw     <= {2'(i), i[0], i[1]};
      tx_near   <= i[0];
      strobe_in <= (i == 3);
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      scan(16'h0086);
      chk("cfg", 32'({i[1], i[0], i == 3}), 32'({wire_sync_sel, near_sel, align_mode}));
      chk("analog_mv", exp_mv(v1[i], i % 2), 32'(analog_mv));
      chk("align_led", i == 3 ? 32'h0000_ff79 : 32'h0000_0000, 32'(align_led));
      xfer(1'b0, 32'(beam_eval_pkg::FIRST_OFS), 32'h0001_0002, "first");
      xfer(1'b0, 32'(beam_eval_pkg::LAST_OFS), 32'h0010_0008, "last");
      xfer(1'b0, 32'(beam_eval_pkg::COUNT_OFS), 32'h0007_0003, "count");
      scan(16'hffff);
      chk("analog_mv", exp_mv(v2[i], i % 2), 32'(analog_mv));
      chk("sync_lost", (i < 2) ? 32'h0000_0001 : 32'h0000_0000, 32'(sync_lost));
      $display("config %0d done", i);
    end
    xfer(1'b1, 32'(beam_eval_pkg::ANALOG_OFS), 32'h0000_0000, "ro");
    xfer(1'b0, 32'(beam_eval_pkg::ANALOG_OFS), exp_mv(1, 1), "analog reg");
    xfer(1'b0, 32'h0000_0020, 32'h0000_0000, "unmapped");
    xfer(1'b1, 32'(beam_eval_pkg::CTRL_OFS), 32'h0000_0000, "ctrl wr");
    xfer(1'b0, 32'(beam_eval_pkg::CTRL_OFS), 32'h0000_0000, "ctrl off");
    xfer(1'b1, 32'(beam_eval_pkg::CTRL_OFS), 32'h0000_0001, "ctrl wr");
    xfer(1'b0, 32'(beam_eval_pkg::CTRL_OFS), 32'h0000_0001, "ctrl on");
    chk("hresp", 32'h0000_0000, 32'(hresp));
    $display("register test done");
    @(posedge hclk);
    hresetn <= 1'b0;
    mis     <= 1'b1;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, 32'(beam_eval_pkg::STATUS_OFS), 32'h0000_017f, "status");
    $display("mismatch test done");
    final_report();
  end
endmodule
